// ===== design/addr_decode_pkg.sv
// Constants, reset values and state codes for the system address decoder.
// Assumes a single 32-bit processor bus on one clock with a synchronous reset.
package addr_decode_pkg;

  // ****************************************************************
  // Memory selects
  // ****************************************************************
  localparam int          NUM_MEM       = 4;
  localparam int          MEM_ROM       = 0;
  localparam int          MEM_PFLASH    = 1;
  localparam int          MEM_DFLASH    = 2;
  localparam int          MEM_RAM       = 3;
  localparam int          ROM_PHYS_AW   = 12;
  localparam int          SIZE_CODE_MAX = 14;
  localparam logic [31:0] SIZE_UNIT     = 32'h0000_0400;

  // Reset-default map: base and size code, size being 1 kB << code.
  localparam logic [31:0] ROM_RST_BASE  = 32'h0000_0000;
  localparam logic [3:0]  ROM_RST_SIZE  = 4'h6;
  localparam logic [31:0] PF_RST_BASE   = 32'h0001_0000;
  localparam logic [3:0]  PF_RST_SIZE   = 4'h5;
  localparam logic [31:0] DF_BASE       = 32'h0001_8800;
  localparam logic [3:0]  DF_SIZE       = 4'h1;
  localparam logic [31:0] RAM_BASE      = 32'h0001_9000;
  localparam logic [3:0]  RAM_SIZE      = 4'h2;

  // Normal map loaded by the boot firmware.
  localparam logic [31:0] ROM_NRM_BASE  = 32'h0001_0000;
  localparam logic [3:0]  ROM_NRM_SIZE  = 4'h2;
  localparam logic [31:0] PF_NRM_BASE   = 32'h0000_0000;
  localparam logic [3:0]  PF_NRM_SIZE   = 4'h5;

  // ****************************************************************
  // Peripheral windows
  // ****************************************************************
  localparam int          NUM_LOOP      = 13;
  localparam logic [31:0] LOOP_BASE0    = 32'h0002_0000;
  localparam int          LOOP_SHIFT    = 16;
  localparam int          NUM_SYSP      = 6;
  localparam logic [5:0][31:0] SYSP_BASE = {32'hFFF7_FD00, 32'hFFF7_FA00, 32'hFFF7_F600,
                                            32'hFFF7_F000, 32'hFFF7_ED00, 32'hFFF7_EC00};
  localparam logic [18:0] LINE_REGION   = 19'h7FFBF;
  localparam int          NUM_LINES     = 8;

  // ****************************************************************
  // System windows and own register offsets
  // ****************************************************************
  localparam logic [31:0] MMC_LO        = 32'hFFFF_FD00;
  localparam logic [31:0] MMC_HI        = 32'hFFFF_FDFF;
  localparam logic [31:0] DEC_LO        = 32'hFFFF_FE00;
  localparam logic [31:0] DEC_HI        = 32'hFFFF_FEFF;
  localparam logic [31:0] IRQ_LO        = 32'hFFFF_FF20;
  localparam logic [31:0] IRQ_HI        = 32'hFFFF_FF37;
  localparam logic [31:0] SIG_LO        = 32'hFFFF_FF40;
  localparam logic [31:0] SIG_HI        = 32'hFFFF_FF50;
  localparam logic [31:0] SYS_LO        = 32'hFFFF_FFD0;
  localparam logic [31:0] SYS_HI        = 32'hFFFF_FFEC;
  localparam logic [7:0]  DEC_MAP_CTRL  = 8'h10;
  localparam logic [7:0]  MMC_STRETCH   = 8'h00;
  localparam logic [7:0]  SYS_PERM      = 8'hD0;
  localparam logic [7:0]  SYS_CTRL      = 8'hD4;
  localparam logic [7:0]  SYS_FADDR     = 8'hD8;
  localparam logic [7:0]  SYS_FSTAT     = 8'hDC;
  localparam logic [12:0] PERM_RST      = 13'h1FFF;
  localparam int          PERM_LOOP     = 12;
  localparam int          PERM_LINE0    = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } bus_state_e;

endpackage

// ===== design/system_address_decode_remap.sv
// System address decoder with boot remap, peripheral selects and access protection.
// Assumes the processor holds address, write data and controls stable from
// request until ready, all on the same clock as this block.
`timescale 1ns/1ps

module system_address_decode_remap
  import addr_decode_pkg::*;
(
  input  wire logic                   clk,            // System clock, 100 MHz.
  input  wire logic                   rst_b,          // Synchronous reset, active low.
  input  wire logic                   bus_req,        // Access request, held until ready.
  input  wire logic [31:0]            bus_addr,       // Byte address.
  input  wire logic                   bus_write,      // High for a write.
  input  wire logic                   bus_priv,       // High in privileged mode.
  input  wire logic [31:0]            bus_wdata,      // Write data.
  output logic                        bus_ready,      // Access completes this cycle.
  output logic                        bus_fault,      // Illegal access, with ready.
  output logic [31:0]                 bus_rdata,      // Own register read data.
  output logic [NUM_MEM-1:0]          mem_sel,        // ROM, program/data flash, RAM.
  output logic [23:0]                 mem_offset,     // Offset inside selected memory.
  output logic [NUM_LOOP-1:0]         loop_sel,       // Control-loop peripheral selects.
  output logic [NUM_LINES-1:0]        periph_sel,     // 1 kB peripheral select lines.
  output logic                        irq_unit_sel,   // Interrupt unit window.
  output logic                        sig_unit_sel,   // Signature unit window.
  output logic                        normal_map,     // Normal map active.
  output logic [2:0]                  clk_speed_sel,  // Processor clock speed setting.
  output logic                        sys_reset_req   // One-cycle reset request.
);
  import addr_decode_pkg::*;

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  logic [NUM_MEM-1:0][31:0] mem_base;
  logic [NUM_MEM-1:0][3:0]  mem_size;
  logic [31:0]              stretch;
  logic [12:0]              user_perm;
  logic                     reset_on_illegal;
  logic [31:0]              fault_addr;
  logic                     fault_flag;
  bus_state_e               state;
  logic [3:0]               cnt;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [NUM_MEM-1:0][31:0] mem_mask;
  logic [NUM_MEM-1:0]       mem_hit;
  logic [NUM_MEM-1:0]       mem_first;
  logic [NUM_LOOP-1:0]      loop_hit;
  logic [NUM_SYSP-1:0]      sysp_hit;
  logic [2:0]               line;
  logic                     dec_hit;
  logic                     mmc_hit;
  logic                     sys_hit;
  logic                     irq_hit;
  logic                     sig_hit;
  logic                     cfg_hit;
  logic                     any_hit;
  logic                     allowed;
  logic                     illegal;
  logic                     direct;
  logic [3:0]               line_stretch;
  logic [7:0]               off;
  logic                     cfg_wr;
  logic                     fault_ev;
  logic [31:0]              rd_mux;

  // One comparator per memory select; a region is 1 kB << size code.
  for (genvar i = 0; i < NUM_MEM; i++) begin : g_mem
    assign mem_mask[i] = (SIZE_UNIT << mem_size[i]) - 32'h0000_0001;
    assign mem_hit[i]  = ((bus_addr ^ mem_base[i]) & ~mem_mask[i]) == 32'h0000_0000;
  end

  // Lowest index wins, so ROM takes precedence should software overlap regions.
  always_comb begin
    mem_first = '0;
    for (int i = NUM_MEM - 1; i >= 0; i--) begin
      if (mem_hit[i]) begin
        mem_first    = '0;
        mem_first[i] = 1'b1;
      end
    end
  end

  // Loop peripherals sit one per 64 kB step, each a 256-byte window.
  for (genvar j = 0; j < NUM_LOOP; j++) begin : g_loop
    localparam logic [31:0] BASE = LOOP_BASE0 + (32'(j) << LOOP_SHIFT);
    assign loop_hit[j] = bus_addr[31:8] == BASE[31:8];
  end

  // Upper system peripherals, each a 256-byte window.
  for (genvar k = 0; k < NUM_SYSP; k++) begin : g_sysp
    assign sysp_hit[k] = bus_addr[31:8] == SYSP_BASE[k][31:8];
  end

  // System unit windows near the top of the address space.
  assign dec_hit = bus_addr >= DEC_LO && bus_addr <= DEC_HI;
  assign mmc_hit = bus_addr >= MMC_LO && bus_addr <= MMC_HI;
  assign sys_hit = bus_addr >= SYS_LO && bus_addr <= SYS_HI;
  assign irq_hit = bus_addr >= IRQ_LO && bus_addr <= IRQ_HI;
  assign sig_hit = bus_addr >= SIG_LO && bus_addr <= SIG_HI;
  assign cfg_hit = dec_hit | mmc_hit | sys_hit;
  assign off     = bus_addr[7:0];

  // The 1 kB line follows from address bits 12:10 inside the 8 kB line region.
  assign line = bus_addr[12:10];

  // Every target lives in one address range on the same bus.
  assign any_hit = (|mem_hit) | (|loop_hit) | (|sysp_hit) | cfg_hit
                   | irq_hit | sig_hit;

  // User mode reaches memory, loop and line regions only with their permission bit set; the interrupt and signature units and own register
  // windows stay reachable; user writes to the own registers are dropped further below.
  always_comb begin
    allowed = bus_priv;
    if (!bus_priv) begin
      if (|mem_hit) begin
        allowed = |(mem_first & user_perm[NUM_MEM-1:0]);
      end else if (|loop_hit) begin
        allowed = user_perm[PERM_LOOP];
      end else if (|sysp_hit) begin
        allowed = user_perm[PERM_LINE0 + 32'(line)];
      end else begin
        allowed = 1'b1;
      end
    end
  end

  // A hole in the map is as illegal as a protection breach.
  assign illegal  = !any_hit || !allowed;
  assign fault_ev = state == ST_IDLE && bus_req && illegal;

  // Stretch setting of the addressed peripheral line.
  assign line_stretch = stretch[4*line +: 4];

  // Accesses that finish in the request cycle: memories, loop windows, the
  // interrupt and signature units, unstretched lines and illegal accesses.
  assign direct = illegal || (!cfg_hit && !((|sysp_hit) && line_stretch != 4'h0));

  // ****************************************************************
  // Selects and handshake
  // ****************************************************************
  // Selects follow the live request, so stretched lines stay selected while waiting.
  always_comb begin
    mem_sel      = '0;
    loop_sel     = '0;
    periph_sel   = '0;
    irq_unit_sel = 1'b0;
    sig_unit_sel = 1'b0;
    if (bus_req && !illegal) begin
      mem_sel      = mem_first;
      loop_sel     = loop_hit;
      irq_unit_sel = irq_hit;
      sig_unit_sel = sig_hit;
      if (|sysp_hit) begin
        periph_sel[line] = 1'b1;
      end
    end
  end

  // ROM offsets wrap on the physical 4 kB, which gives the aliased copies.
  always_comb begin
    mem_offset = 24'h00_0000;
    for (int i = 0; i < NUM_MEM; i++) begin
      if (mem_first[i]) begin
        mem_offset = 24'(bus_addr & mem_mask[i]);
      end
    end
    if (mem_first[MEM_ROM]) begin
      mem_offset = {12'h000, bus_addr[ROM_PHYS_AW-1:0]};
    end
  end

  assign bus_ready = (state == ST_IDLE && bus_req && direct) || state == ST_DONE;
  assign bus_fault = fault_ev;

  // Own registers always take two wait states; stretched lines take their count plus one.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (bus_req && !direct) begin
            state <= ST_WAIT;
            cnt   <= cfg_hit ? 4'h0 : line_stretch - 4'h1;
          end
        end
        ST_WAIT: begin
          if (cnt == 4'h0) begin
            state <= ST_DONE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Own registers
  // ****************************************************************
  // Writes land in the completing cycle, and only from privileged code.
  assign cfg_wr = state == ST_DONE && cfg_hit && bus_write && bus_priv;

  // Memory select registers. The map leaves the reset state only when firmware
  // writes here; it does so after a good checksum, just before jumping to
  // flash location zero, and never when it must stay in control itself.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_base   <= {RAM_BASE, DF_BASE, PF_RST_BASE, ROM_RST_BASE};
      mem_size   <= {RAM_SIZE, DF_SIZE, PF_RST_SIZE, ROM_RST_SIZE};
      normal_map <= 1'b0;
    end else if (cfg_wr && dec_hit) begin
      if (off == DEC_MAP_CTRL && bus_wdata[0]) begin
        mem_base[MEM_ROM]    <= ROM_NRM_BASE;
        mem_size[MEM_ROM]    <= ROM_NRM_SIZE;
        mem_base[MEM_PFLASH] <= PF_NRM_BASE;
        mem_size[MEM_PFLASH] <= PF_NRM_SIZE;
        normal_map           <= 1'b1;
      end else if (off[7:4] == 4'h0 && off[1:0] == 2'b00) begin
        mem_base[off[3:2]] <= {bus_wdata[31:10], 10'h000};
        mem_size[off[3:2]] <= bus_wdata[3:0] > 4'(SIZE_CODE_MAX) ?
                              4'(SIZE_CODE_MAX) : bus_wdata[3:0];
      end
    end
  end

  // Until remapped, ROM answers at zero and keeps serving bus commands.

  // Peripheral line stretch counts, four bits per line.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stretch <= 32'h0000_0000;
    end else if (cfg_wr && mmc_hit && off == MMC_STRETCH) begin
      stretch <= bus_wdata;
    end
  end

  // System protection settings and clock speed.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      user_perm        <= PERM_RST;
      reset_on_illegal <= 1'b0;
      clk_speed_sel    <= 3'h0;
    end else if (cfg_wr && sys_hit) begin
      if (off == SYS_PERM) begin
        user_perm <= bus_wdata[12:0];
      end
      if (off == SYS_CTRL) begin
        reset_on_illegal <= bus_wdata[0];
        clk_speed_sel    <= bus_wdata[3:1];
      end
    end
  end

  // Fault capture: a new fault wins over a clear in the same cycle, so no
  // event is lost. The address of the latest fault is kept.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fault_flag <= 1'b0;
      fault_addr <= 32'h0000_0000;
    end else if (fault_ev) begin
      fault_flag <= 1'b1;
      fault_addr <= bus_addr;
    end else if (cfg_wr && sys_hit && off == SYS_FSTAT && bus_wdata[0]) begin
      fault_flag <= 1'b0;
    end
  end

  // Reset request pulse when the system unit is set to reset on illegal access.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= fault_ev && reset_on_illegal;
    end
  end

  // Read mux; unmapped offsets inside own windows read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dec_hit) begin
      if (off == DEC_MAP_CTRL) begin
        rd_mux = {31'h0, normal_map};
      end else if (off[7:4] == 4'h0 && off[1:0] == 2'b00) begin
        rd_mux = {mem_base[off[3:2]][31:10], 6'h00, mem_size[off[3:2]]};
      end
    end else if (mmc_hit && off == MMC_STRETCH) begin
      rd_mux = stretch;
    end else if (sys_hit) begin
      unique case (off)
        SYS_PERM:  rd_mux = {19'h0, user_perm};
        SYS_CTRL:  rd_mux = {28'h0, clk_speed_sel, reset_on_illegal};
        SYS_FADDR: rd_mux = fault_addr;
        SYS_FSTAT: rd_mux = {31'h0, fault_flag};
        default:   rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data is registered on the way into the completing cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_rdata <= 32'h0000_0000;
    end else if (state == ST_WAIT && cnt == 4'h0) begin
      bus_rdata <= rd_mux;
    end
  end

endmodule

// ===== testbench/cpu_bus_model.sv
// Processor-side model: issues one access at a time on the decoder's bus.
// Assumes ready is combinational and sampled at the rising edge of clk.
`timescale 1ns/1ps

module cpu_bus_model (
  input  wire logic        clk,        // System clock.
  input  wire logic        bus_ready,  // Access completes.
  input  wire logic        bus_fault,  // Access refused.
  input  wire logic [31:0] bus_rdata,  // Read data.
  output logic             bus_req,    // Request, held until ready.
  output logic [31:0]      bus_addr,   // Byte address.
  output logic             bus_write,  // High for a write.
  output logic             bus_priv,   // High in privileged mode.
  output logic [31:0]      bus_wdata   // Write data.
);
  // Quiet bus at time zero.
  initial begin
    bus_req   = 1'b0;
    bus_addr  = 32'h0;
    bus_write = 1'b0;
    bus_priv  = 1'b0;
    bus_wdata = 32'h0;
  end

  // Drive after a falling edge and hold until ready is seen; the mode bit travels
  // with every access, so remaps are only ever issued as the caller asks.
  task automatic access(input logic wr, pv, input logic [31:0] a, d,
                        output logic [31:0] rd, output logic flt, output int ws);
    int n;
    n = 0;
    @(negedge clk);
    bus_req   <= 1'b1;
    bus_addr  <= a;
    bus_write <= wr;
    bus_priv  <= pv;
    bus_wdata <= d;
    #1;
    while (bus_ready !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    rd  = bus_rdata;
    flt = bus_fault;
    ws  = n;
    @(posedge clk);
  endtask

  // Release: address and write data lines no longer hold the last value, so stale decodes cannot pass.
  task automatic idle;
    @(negedge clk);
    bus_req   <= 1'b0;
    bus_addr  <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
  endtask
endmodule

// ===== testbench/system_address_decode_remap_properties.sv
// Concurrent checks on the decoder's ports.
// Assumes one clock and the synchronous active-low reset of the design.
`timescale 1ns/1ps

module system_address_decode_remap_properties
  import addr_decode_pkg::*;
(
  input wire logic                 clk,            // System clock.
  input wire logic                 rst_b,          // Reset, active low.
  input wire logic                 bus_req,        // Request.
  input wire logic [31:0]          bus_addr,       // Address.
  input wire logic                 bus_write,      // Write.
  input wire logic                 bus_priv,       // Privileged.
  input wire logic [31:0]          bus_wdata,      // Write data.
  input wire logic                 bus_ready,      // Ready.
  input wire logic                 bus_fault,      // Fault.
  input wire logic [NUM_MEM-1:0]   mem_sel,        // Memory selects.
  input wire logic [23:0]          mem_offset,     // Memory offset.
  input wire logic [NUM_LOOP-1:0]  loop_sel,       // Loop selects.
  input wire logic [NUM_LINES-1:0] periph_sel,     // Peripheral lines.
  input wire logic                 irq_unit_sel,   // Interrupt unit.
  input wire logic                 sig_unit_sel,   // Signature unit.
  input wire logic                 normal_map,     // Normal map.
  input wire logic [2:0]           clk_speed_sel,  // Clock speed.
  input wire logic                 sys_reset_req   // Reset request.
);
  import addr_decode_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // A request is fresh when nothing was pending in the cycle before.
  logic fresh;
  always_ff @(posedge clk) begin
    fresh <= !rst_b || !bus_req || bus_ready;
  end
  wire logic start  = bus_req && fresh;
  wire logic own    = bus_req && ((bus_addr >= MMC_LO && bus_addr <= DEC_HI) ||
                                  (bus_addr >= SYS_LO && bus_addr <= SYS_HI));
  wire logic in_irq = bus_addr >= IRQ_LO && bus_addr <= IRQ_HI;
  wire logic in_sig = bus_addr >= SIG_LO && bus_addr <= SIG_HI;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_rom_alias: assert property (bus_req && !normal_map && bus_addr[31:16] == 16'h0
    |-> mem_sel == 4'h1 && mem_offset == {12'h0, bus_addr[11:0]}) else $error("rom alias");
  a_pflash_reset: assert property (bus_req && !normal_map && bus_addr[31:15] == 17'h2
    |-> mem_sel == 4'h2 && mem_offset == {9'h0, bus_addr[14:0]}) else $error("pflash map");
  a_data_mems: assert property (bus_req && (bus_addr[31:11] == 21'h31 ||
    bus_addr[31:12] == 20'h19) |-> mem_sel == (bus_addr[12] ? 4'h8 : 4'h4))
    else $error("data memory select");
  a_normal_map: assert property (bus_req && normal_map && (bus_addr[31:15] == 17'h0 ||
    bus_addr[31:12] == 20'h10) |-> mem_sel == (bus_addr[16] ? 4'h1 : 4'h2))
    else $error("normal map select");
  a_loop_window: assert property (bus_req && bus_addr[31:20] == 12'h0 &&
    bus_addr[15:8] == 8'h0 && bus_addr[19:16] >= 4'h2 && bus_addr[19:16] <= 4'hE
    |-> bus_ready && loop_sel == 13'h1 << (bus_addr[19:16] - 4'h2)) else $error("loop sel");
  a_periph_line: assert property (bus_req && bus_addr[31:16] == 16'hFFF7 &&
    bus_addr[15:8] inside {8'hEC, 8'hED, 8'hF0, 8'hF6, 8'hFA, 8'hFD}
    |-> periph_sel == 8'h1 << bus_addr[12:10]) else $error("peripheral line");
  a_unit_select: assert property (bus_req && (in_irq || in_sig)
    |-> irq_unit_sel == in_irq && sig_unit_sel == in_sig) else $error("unit select");
  a_own_wait: assert property (start && own
    |-> !bus_ready ##1 !bus_ready ##1 bus_ready) else $error("own wait state");
  a_unmapped_fault: assert property (start && bus_addr[31:28] == 4'h0 &&
    bus_addr[27:20] != 8'h0 |-> bus_ready && bus_fault && mem_sel == 4'h0)
    else $error("unmapped access");
  a_remap_cause: assert property ($rose(normal_map) |-> $past(bus_ready && bus_write &&
    bus_priv && bus_addr == {DEC_LO[31:8], DEC_MAP_CTRL} && bus_wdata[0]))
    else $error("map changed alone");
  a_user_drop: assert property (bus_ready && bus_write && !bus_priv && own
    |=> $stable(normal_map) && $stable(clk_speed_sel)) else $error("user write taken");
  a_reset_pulse: assert property (sys_reset_req
    |-> $past(bus_ready && bus_fault) ##1 !sys_reset_req) else $error("reset request");

  // Main scenarios reached.
  c_own: cover property (start && own);
  c_fault: cover property (bus_fault);
  c_remap: cover property ($rose(normal_map));
endmodule

bind system_address_decode_remap system_address_decode_remap_properties u_props (
  .clk, .rst_b, .bus_req, .bus_addr, .bus_write, .bus_priv, .bus_wdata, .bus_ready,
  .bus_fault, .mem_sel, .mem_offset, .loop_sel, .periph_sel, .irq_unit_sel,
  .sig_unit_sel, .normal_map, .clk_speed_sel, .sys_reset_req
);

// ===== testbench/system_address_decode_remap_tb.sv
// Self-checking bench for the address decoder with its processor model.
// Assumes the package constants and the hand-over timing of the bus.
`timescale 1ns/1ps

module system_address_decode_remap_tb;
  import addr_decode_pkg::*;

  logic                 clk, rst_b, bus_req, bus_write, bus_priv, bus_ready, bus_fault;
  logic [31:0]          bus_addr, bus_wdata, bus_rdata, rd, a, v;
  logic [NUM_MEM-1:0]   mem_sel;
  logic [23:0]          mem_offset;
  logic [NUM_LOOP-1:0]  loop_sel;
  logic [NUM_LINES-1:0] periph_sel;
  logic [2:0]           clk_speed_sel;
  logic                 irq_unit_sel, sig_unit_sel, normal_map, sys_reset_req, flt, nm;
  int                   ws;
  int                   error_cnt = 0;
  int                   checks = 0;
  integer               seed = 32'h6EFB1F5C;
  logic [31:0]          own_base [3] = '{MMC_LO, DEC_LO, SYS_LO};

  system_address_decode_remap u_dut (
    .clk, .rst_b, .bus_req, .bus_addr, .bus_write, .bus_priv, .bus_wdata, .bus_ready,
    .bus_fault, .bus_rdata, .mem_sel, .mem_offset, .loop_sel, .periph_sel, .irq_unit_sel,
    .sig_unit_sel, .normal_map, .clk_speed_sel, .sys_reset_req
  );
  cpu_bus_model u_cpu (
    .clk, .bus_ready, .bus_fault, .bus_rdata, .bus_req, .bus_addr, .bus_write, .bus_priv,
    .bus_wdata
  );

  // ****************************************************************
  // Clock, compare and access helpers
  // ****************************************************************
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Selects stay valid while the request is held, so they are read just after completion.
  task automatic acc(input logic wr, pv, input logic [31:0] ad, d);
    u_cpu.access(wr, pv, ad, d, rd, flt, ws);
    #1;
  endtask

  function automatic logic [3:0] exp_sel(input logic [31:0] ad, input logic m);
    if (ad[31:11] == 21'h31) return 4'h4;
    if (ad[31:12] == 20'h19) return 4'h8;
    if (m ? ad[31:12] == 20'h10 : ad[31:16] == 16'h0) return 4'h1;
    if (ad[31:15] == (m ? 17'h0 : 17'h2)) return 4'h2;
    return 4'h0;
  endfunction

  function automatic logic [23:0] exp_off(input logic [31:0] ad, input logic [3:0] s);
    return s[1] ? {9'h0, ad[14:0]} : s[2] ? {13'h0, ad[10:0]} : {12'h0, ad[11:0]};
  endfunction

  task automatic mem_test(input logic [31:0] ad);
    logic [3:0] s;
    s = exp_sel(ad, nm);
    acc(1'b0, 1'b1, ad, 32'h0);
    chk(mem_sel, s);
    chk(flt, s == 4'h0);
    chk(ws, 0);
    if (s != 4'h0) begin
      chk(mem_offset, exp_off(ad, s));
    end
  endtask

  // Map edges in both maps, then random word addresses in the low region.
  task automatic sweep;
    logic [31:0] c [15] = '{32'h0, 32'h5ABC, 32'h7FFF, 32'h8000, 32'hFFFF, 32'h1_0000,
      32'h1_0FFF, 32'h1_1000, 32'h1_7FFF, 32'h1_8000, 32'h1_8800, 32'h1_8FFF, 32'h1_9000,
      32'h1_9FFF, 32'h1_A000};
    foreach (c[k]) mem_test(c[k]);
    repeat (16) mem_test($random(seed) & 32'h0001_FFFC);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog at 20000 cycles, sized well beyond the roughly 150 cycles the tests take.
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    nm = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk(normal_map, 0);
    chk(clk_speed_sel, 0);
    sweep();
    done("reset map");
    for (int j = 0; j < NUM_LOOP; j++) begin
      acc(1'b0, 1'b0, LOOP_BASE0 + (j << LOOP_SHIFT) + ($random(seed) & 32'hFC), 32'h0);
      chk(loop_sel, 13'h1 << j);
    end
    acc(1'b0, 1'b1, 32'h000E_0100, 32'h0);
    chk(flt, 1'b1);
    for (int i = 0; i < NUM_SYSP; i++) begin
      acc(1'b0, 1'b0, SYSP_BASE[i] + 32'h4, 32'h0);
      chk(periph_sel, 8'h1 << SYSP_BASE[i][12:10]);
    end
    acc(1'b0, 1'b0, IRQ_HI, 32'h0);
    chk(irq_unit_sel, 1'b1);
    acc(1'b0, 1'b0, SIG_LO, 32'h0);
    chk(sig_unit_sel, 1'b1);
    foreach (own_base[k]) begin
      acc(1'b0, 1'b0, own_base[k], 32'h0);
      chk(ws, 2);
    end
    done("windows");
    v = $random(seed);
    acc(1'b1, 1'b1, SYS_LO + 32'h4, {28'h0, v[2:0], 1'b0});
    chk(clk_speed_sel, v[2:0]);
    acc(1'b1, 1'b0, SYS_LO + 32'h4, {28'h0, ~v[2:0], 1'b0});
    chk(clk_speed_sel, v[2:0]);
    acc(1'b1, 1'b0, DEC_LO + 32'h10, 32'h1);
    chk(flt, 1'b0);
    chk(normal_map, 1'b0);
    acc(1'b1, 1'b1, MMC_LO, 32'h0000_2000);
    acc(1'b0, 1'b0, SYSP_BASE[0], 32'h0);
    chk(ws, 3);
    acc(1'b1, 1'b1, MMC_LO, 32'h0);
    done("protection");
    acc(1'b1, 1'b1, SYS_LO + 32'h4, 32'h1);
    a = 32'h0100_0000 | ($random(seed) & 32'h0FFF_FFFC);
    acc(1'b0, 1'b0, a, 32'h0);
    chk(flt, 1'b1);
    chk(sys_reset_req, 1'b1);
    acc(1'b0, 1'b0, SYS_LO + 32'h8, 32'h0);
    chk(rd, a);
    acc(1'b0, 1'b0, SYS_LO + 32'hC, 32'h0);
    chk(rd[0], 1'b1);
    acc(1'b1, 1'b1, SYS_LO + 32'hC, 32'h1);
    acc(1'b0, 1'b0, SYS_LO + 32'hC, 32'h0);
    chk(rd[0], 1'b0);
    acc(1'b1, 1'b1, SYS_LO + 32'h4, 32'h0);
    done("fault");
    acc(1'b1, 1'b1, DEC_LO + 32'h10, 32'h1);
    nm = 1'b1;
    chk(normal_map, 1'b1);
    acc(1'b0, 1'b0, DEC_LO + 32'h10, 32'h0);
    chk(rd[0], 1'b1);
    sweep();
    acc(1'b1, 1'b1, DEC_LO + 32'hC, RAM_BASE | 32'hF);
    acc(1'b0, 1'b0, DEC_LO + 32'hC, 32'h0);
    chk(rd, RAM_BASE | SIZE_CODE_MAX);
    done("normal map");
    u_cpu.idle();
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    nm = 1'b0;
    chk(normal_map, 1'b0);
    mem_test(32'h0000_F124);
    done("second reset");
    report_and_stop();
  end
endmodule
